// ===== hw/ebs_pkg.sv
package ebs_pkg;

  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 20;
  localparam int DATA_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int A0_BIT  = 0;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST   = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST   = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO  = 8'h00;
  localparam logic              STROBE_OFF = 1'b1;
  localparam logic              ACK_OFF_N  = 1'b1;

  // ---------------------------------------------------------------
  // bus sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_STROBE = 3'h2,
    ST_END    = 3'h3,
    ST_HOLD   = 3'h4
  } ebs_state_t;

  // ---------------------------------------------------------------
  // byte lane decode
  // ---------------------------------------------------------------
  function automatic logic lane_lo_en(input logic a0, input logic wide);
    lane_lo_en = !a0 || wide;
  endfunction

  function automatic logic lane_hi_en(input logic a0, input logic wide, input logic bus16);
    lane_hi_en = bus16 && (a0 || wide);
  endfunction

endpackage

// ===== hw/ebs_data_lane.sv
`timescale 1ns/1ps

module ebs_data_lane
(
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_b_i,
  // phase controls, aligned to the next bus phase
  input  wire logic                         load_addr_i,
  input  wire logic                         load_data_i,
  input  wire logic                         release_i,
  input  wire logic                         sample_i,
  // transfer attributes
  input  wire logic                         bus16_i,
  input  wire logic                         a0_i,
  input  wire logic                         wide_i,
  input  wire logic [ebs_pkg::BYTE_W-1:0]   addr_lo_i,
  input  wire logic [ebs_pkg::DATA_W-1:0]   wdata_i,
  // data pins
  input  wire logic [ebs_pkg::DATA_W-1:0]   data_i,
  output logic      [ebs_pkg::DATA_W-1:0]   data_o,
  output logic                              data_oe_o,
  output logic      [ebs_pkg::DATA_W-1:0]   rdata_o
);

  typedef struct packed
  {
    logic [ebs_pkg::DATA_W-1:0] dout;
    logic                       oe;
    logic [ebs_pkg::DATA_W-1:0] rdata;
  } ebs_lane_t;

  ebs_lane_t lane_q;
  ebs_lane_t lane_d;

  // ---------------------------------------------------------------
  // lane decode
  // ---------------------------------------------------------------
  function automatic logic both_lanes(input logic bus16, input logic wide);
    both_lanes = bus16 && wide;
  endfunction

  function automatic logic upper_lane(input logic bus16, input logic a0);
    upper_lane = bus16 && a0;
  endfunction

  // ---------------------------------------------------------------
  // lane steering
  // ---------------------------------------------------------------
  always_comb
  begin
    lane_d = lane_q;
    if (load_addr_i)
    begin
      lane_d.dout = {ebs_pkg::BYTE_ZERO, addr_lo_i};
      lane_d.oe   = 1'b1;
    end
    else if (load_data_i)
    begin
      if (both_lanes(bus16_i, wide_i))
        lane_d.dout = wdata_i;
      else if (upper_lane(bus16_i, a0_i))
        lane_d.dout = {wdata_i[ebs_pkg::BYTE_W-1:0], ebs_pkg::BYTE_ZERO};
      else
        lane_d.dout = {ebs_pkg::BYTE_ZERO, wdata_i[ebs_pkg::BYTE_W-1:0]};
      lane_d.oe = 1'b1;
    end
    else if (release_i)
    begin
      lane_d.oe = 1'b0;
    end
    if (sample_i)
    begin
      if (both_lanes(bus16_i, wide_i))
        lane_d.rdata = data_i;
      else if (upper_lane(bus16_i, a0_i))
        lane_d.rdata = {ebs_pkg::BYTE_ZERO, data_i[ebs_pkg::DATA_W-1:ebs_pkg::BYTE_W]};
      else
        lane_d.rdata = {ebs_pkg::BYTE_ZERO, data_i[ebs_pkg::BYTE_W-1:0]};
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lane_q.dout  <= ebs_pkg::DATA_RST;
      lane_q.oe    <= 1'b0;
      lane_q.rdata <= ebs_pkg::DATA_RST;
    end
    else
    begin
      lane_q <= lane_d;
    end
  end

  assign data_o    = lane_q.dout;
  assign data_oe_o = lane_q.oe;
  assign rdata_o   = lane_q.rdata;

endmodule

// ===== hw/ebs_bus_ctrl.sv
`timescale 1ns/1ps

// Contract
// - strobe scheme selectable: split byte stores plus read, or one store plus byte enable.
// - split scheme, 16-bit bus: even-address writes drive low_byte_store_n low.
// - split scheme: odd-address writes drive high_byte_store_n low.
// - read strobe low during reads; external device drives data meanwhile.
// - single scheme: writes happen while the single store strobe is low.
// - single scheme: upper_byte_enable_n low whenever an odd address is accessed.
// - while hold request is low, stay in hold and run no bus cycles.
// - bus_grant_ack_n low for as long as the hold state lasts.
// - address latch strobe lets external latches capture the address.
// - while wait input is low, remain in the strobe state.
// - 8-bit multiplexed bus: low address then data on the same lines.
module ebs_bus_ctrl
(
  // clock and reset
  input  wire logic                         CLK_SYS_I,
  input  wire logic                         RST_B_I,
  // bus configuration
  input  wire logic                         CFG_SINGLE_STORE_I,
  input  wire logic                         CFG_BUS16_I,
  input  wire logic                         CFG_MUX8_I,
  // internal request port
  input  wire logic                         REQ_VALID_I,
  output logic                              REQ_READY_O,
  input  wire logic                         REQ_WRITE_I,
  input  wire logic                         REQ_WIDE_I,
  input  wire logic [ebs_pkg::ADDR_W-1:0]   REQ_ADDR_I,
  input  wire logic [ebs_pkg::DATA_W-1:0]   REQ_WDATA_I,
  output logic                              RSP_VALID_O,
  output logic      [ebs_pkg::DATA_W-1:0]   RSP_RDATA_O,
  // address and data pins
  output logic      [ebs_pkg::ADDR_W-1:0]   ADDR_O,
  output logic                              ADDR_HI_OE_O,
  output logic                              ADDR_LO_OE_O,
  input  wire logic [ebs_pkg::DATA_W-1:0]   DATA_I,
  output logic      [ebs_pkg::DATA_W-1:0]   DATA_O,
  output logic                              DATA_OE_O,
  // strobe pins
  output logic                              LOW_BYTE_STORE_N_O,
  output logic                              HIGH_BYTE_STORE_N_O,
  output logic                              READ_STROBE_N_O,
  output logic                              STROBE_OE_O,
  output logic                              ADDR_LATCH_O,
  // hold and wait pins
  input  wire logic                         HOLD_REQ_N_I,
  output logic                              BUS_GRANT_ACK_N_O,
  input  wire logic                         WAIT_N_I
);

  typedef struct packed
  {
    ebs_pkg::ebs_state_t          st;
    logic                         req_ready;
    logic                         write;
    logic                         wide;
    logic                         single;
    logic                         bus16;
    logic                         mux8;
    logic [ebs_pkg::ADDR_W-1:0]   addr;
    logic [ebs_pkg::DATA_W-1:0]   wdata;
    logic                         ale;
    logic                         lo_n;
    logic                         hi_n;
    logic                         rd_n;
    logic                         strobe_oe;
    logic                         addr_hi_oe;
    logic                         addr_lo_oe;
    logic                         ack_n;
    logic                         rsp_valid;
  } ebs_ctl_t;

  ebs_ctl_t ctl_q;
  ebs_ctl_t ctl_d;

  logic     take;
  logic     a0;
  logic     load_addr;
  logic     load_data;
  logic     release_lane;
  logic     sample;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // the multiplexed scheme only exists on the 8-bit bus
  function automatic logic mux8_sel(input logic mux8, input logic bus16);
    mux8_sel = mux8 && !bus16;
  endfunction

  // a word access needs the 16-bit bus and an even address
  function automatic logic wide_sel(input logic wide, input logic bus16, input logic a0);
    wide_sel = wide && bus16 && !a0;
  endfunction

  // the upper byte takes part: odd byte, or word on the 16-bit bus
  function automatic logic upper_sel(input logic wide, input logic bus16, input logic a0);
    upper_sel = a0 || (wide && bus16);
  endfunction

  // the strobe phase ends at an edge that sees the wait input high
  function automatic logic strobe_done(input ebs_pkg::ebs_state_t st, input logic wait_n);
    strobe_done = (st == ebs_pkg::ST_STROBE) && wait_n;
  endfunction

  // ---------------------------------------------------------------
  // request acceptance
  // ---------------------------------------------------------------
  assign take = REQ_VALID_I && ctl_q.req_ready;
  assign a0   = ctl_q.addr[ebs_pkg::A0_BIT];

  // ---------------------------------------------------------------
  // bus sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    ctl_d           = ctl_q;
    ctl_d.rsp_valid = 1'b0;
    unique case (ctl_q.st)
      ebs_pkg::ST_IDLE:
      begin
        if (take)
        begin
          ctl_d.st         = ebs_pkg::ST_ADDR;
          ctl_d.write      = REQ_WRITE_I;
          ctl_d.single     = CFG_SINGLE_STORE_I;
          ctl_d.bus16      = CFG_BUS16_I;
          ctl_d.mux8       = mux8_sel(CFG_MUX8_I, CFG_BUS16_I);
          ctl_d.wide       = wide_sel(REQ_WIDE_I, CFG_BUS16_I, REQ_ADDR_I[ebs_pkg::A0_BIT]);
          ctl_d.addr       = REQ_ADDR_I;
          ctl_d.wdata      = REQ_WDATA_I;
          ctl_d.ale        = 1'b1;
          ctl_d.addr_hi_oe = 1'b1;
          ctl_d.addr_lo_oe = !mux8_sel(CFG_MUX8_I, CFG_BUS16_I);
          ctl_d.strobe_oe  = 1'b1;
          // byte enable follows the address from the address phase on
          if (CFG_SINGLE_STORE_I)
            ctl_d.hi_n = !upper_sel(REQ_WIDE_I, CFG_BUS16_I,
                                    REQ_ADDR_I[ebs_pkg::A0_BIT]);
        end
        else if (!HOLD_REQ_N_I)
        begin
          ctl_d.st         = ebs_pkg::ST_HOLD;
          ctl_d.ack_n      = 1'b0;
          ctl_d.strobe_oe  = 1'b0;
          ctl_d.addr_hi_oe = 1'b0;
          ctl_d.addr_lo_oe = 1'b0;
        end
      end
      ebs_pkg::ST_ADDR:
      begin
        ctl_d.st  = ebs_pkg::ST_STROBE;
        ctl_d.ale = 1'b0;
        // the shared low lines now carry data, not address
        if (ctl_q.mux8)
          ctl_d.addr_lo_oe = 1'b0;
        if (ctl_q.write)
        begin
          if (ctl_q.single)
          begin
            ctl_d.lo_n = 1'b0;
          end
          else
          begin
            ctl_d.lo_n = !ebs_pkg::lane_lo_en(a0, ctl_q.wide);
            ctl_d.hi_n = !ebs_pkg::lane_hi_en(a0, ctl_q.wide, ctl_q.bus16);
            // an 8-bit bus has no upper lane, yet an odd byte still needs its strobe
            if (a0)
            begin
              ctl_d.hi_n = 1'b0;
            end
          end
        end
        else
        begin
          ctl_d.rd_n = 1'b0;
        end
      end
      ebs_pkg::ST_STROBE:
      begin
        // a low wait input keeps every strobe where it is
        if (WAIT_N_I)
        begin
          ctl_d.st        = ebs_pkg::ST_END;
          ctl_d.lo_n      = ebs_pkg::STROBE_OFF;
          ctl_d.rd_n      = ebs_pkg::STROBE_OFF;
          ctl_d.rsp_valid = 1'b1;
          if (!ctl_q.single)
            ctl_d.hi_n = ebs_pkg::STROBE_OFF;
        end
      end
      ebs_pkg::ST_END:
      begin
        // the byte enable outlives the store strobe by one cycle
        ctl_d.st         = ebs_pkg::ST_IDLE;
        ctl_d.hi_n       = ebs_pkg::STROBE_OFF;
        ctl_d.addr_lo_oe = 1'b1;
      end
      ebs_pkg::ST_HOLD:
      begin
        // the bus comes back parked, driven as in idle
        if (HOLD_REQ_N_I)
        begin
          ctl_d.st         = ebs_pkg::ST_IDLE;
          ctl_d.ack_n      = ebs_pkg::ACK_OFF_N;
          ctl_d.strobe_oe  = 1'b1;
          ctl_d.addr_hi_oe = 1'b1;
          ctl_d.addr_lo_oe = 1'b1;
        end
      end
      default:
      begin
        ctl_d.st = ebs_pkg::ST_IDLE;
      end
    endcase
    // no new cycle is offered while a hold is requested
    ctl_d.req_ready = (ctl_d.st == ebs_pkg::ST_IDLE) && HOLD_REQ_N_I;
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ctl_q.st         <= ebs_pkg::ST_IDLE;
      ctl_q.req_ready  <= 1'b0;
      ctl_q.write      <= 1'b0;
      ctl_q.wide       <= 1'b0;
      ctl_q.single     <= 1'b0;
      ctl_q.bus16      <= 1'b0;
      ctl_q.mux8       <= 1'b0;
      ctl_q.addr       <= ebs_pkg::ADDR_RST;
      ctl_q.wdata      <= ebs_pkg::DATA_RST;
      ctl_q.ale        <= 1'b0;
      ctl_q.lo_n       <= ebs_pkg::STROBE_OFF;
      ctl_q.hi_n       <= ebs_pkg::STROBE_OFF;
      ctl_q.rd_n       <= ebs_pkg::STROBE_OFF;
      ctl_q.strobe_oe  <= 1'b1;
      ctl_q.addr_hi_oe <= 1'b1;
      ctl_q.addr_lo_oe <= 1'b1;
      ctl_q.ack_n      <= ebs_pkg::ACK_OFF_N;
      ctl_q.rsp_valid  <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end

  // ---------------------------------------------------------------
  // data lane controls, aligned with the next phase
  // ---------------------------------------------------------------
  always_comb
  begin
    // the address byte comes straight from the request port at the take edge
    load_addr    = take && mux8_sel(CFG_MUX8_I, CFG_BUS16_I);
    load_data    = (ctl_q.st == ebs_pkg::ST_ADDR) && ctl_q.write;
    release_lane = ((ctl_q.st == ebs_pkg::ST_ADDR) && !ctl_q.write) ||
                   (ctl_q.st == ebs_pkg::ST_END) ||
                   (ctl_d.st == ebs_pkg::ST_HOLD);
    sample       = strobe_done(ctl_q.st, WAIT_N_I) && !ctl_q.write;
  end

  ebs_data_lane u_lane
  (
    .clk_i       (CLK_SYS_I),
    .rst_b_i     (RST_B_I),
    .load_addr_i (load_addr),
    .load_data_i (load_data),
    .release_i   (release_lane),
    .sample_i    (sample),
    .bus16_i     (ctl_q.bus16),
    .a0_i        (a0),
    .wide_i      (ctl_q.wide),
    .addr_lo_i   (REQ_ADDR_I[ebs_pkg::BYTE_W-1:0]),
    .wdata_i     (ctl_q.wdata),
    .data_i      (DATA_I),
    .data_o      (DATA_O),
    .data_oe_o   (DATA_OE_O),
    .rdata_o     (RSP_RDATA_O)
  );

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  assign REQ_READY_O         = ctl_q.req_ready;
  assign RSP_VALID_O         = ctl_q.rsp_valid;
  assign ADDR_O              = ctl_q.addr;
  assign ADDR_HI_OE_O        = ctl_q.addr_hi_oe;
  assign ADDR_LO_OE_O        = ctl_q.addr_lo_oe;
  assign LOW_BYTE_STORE_N_O  = ctl_q.lo_n;
  assign HIGH_BYTE_STORE_N_O = ctl_q.hi_n;
  assign READ_STROBE_N_O     = ctl_q.rd_n;
  assign STROBE_OE_O         = ctl_q.strobe_oe;
  assign ADDR_LATCH_O        = ctl_q.ale;
  assign BUS_GRANT_ACK_N_O   = ctl_q.ack_n;

endmodule

// ===== testbench/ebs_ext_mem.sv
`timescale 1ns/1ps

module ebs_ext_mem
#(
  parameter logic [15:0] PAT = 16'hC3A5
)
(
  // bus side
  input  wire logic                       clk_i,
  input  wire logic [ebs_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                       ale_i,
  input  wire logic                       rd_n_i,
  output logic      [ebs_pkg::DATA_W-1:0] data_o
);
  logic [19:0] lat_q;
  logic [15:0] last_q;
  logic [15:0] rd_val;

  assign rd_val = PAT ^ lat_q[15:0];
  // released lines show the inverse of the last value driven
  assign data_o = rd_n_i ? ~last_q : rd_val;

  always_ff @(posedge clk_i)
  begin
    if (ale_i)
      lat_q <= addr_i;
    if (!rd_n_i)
      last_q <= rd_val;
  end
endmodule

// ===== testbench/ebs_bus_ctrl_asserts.sv
`timescale 1ns/1ps

module ebs_bus_asserts
(
  // clock and reset
  input  wire logic                       CLK_SYS_I,
  input  wire logic                       RST_B_I,
  // request port
  input  wire logic                       REQ_VALID_I,
  input  wire logic                       REQ_READY_O,
  input  wire logic                       REQ_WRITE_I,
  input  wire logic [ebs_pkg::ADDR_W-1:0] REQ_ADDR_I,
  input  wire logic                       RSP_VALID_O,
  // bus pins
  input  wire logic [ebs_pkg::ADDR_W-1:0] ADDR_O,
  input  wire logic                       ADDR_HI_OE_O,
  input  wire logic                       ADDR_LO_OE_O,
  input  wire logic [ebs_pkg::DATA_W-1:0] DATA_O,
  input  wire logic                       DATA_OE_O,
  input  wire logic                       LOW_BYTE_STORE_N_O,
  input  wire logic                       READ_STROBE_N_O,
  input  wire logic                       STROBE_OE_O,
  input  wire logic                       ADDR_LATCH_O,
  input  wire logic                       HOLD_REQ_N_I,
  input  wire logic                       BUS_GRANT_ACK_N_O,
  input  wire logic                       WAIT_N_I
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_B_I);

  // ----
  // hold
  // ----
  a_grant_cause: assert property ($fell(BUS_GRANT_ACK_N_O) |-> !$past(HOLD_REQ_N_I))
    else $error("grant without hold request");
  a_grant_quiet: assert property (!BUS_GRANT_ACK_N_O |-> !REQ_READY_O && !ADDR_LATCH_O)
    else $error("bus activity during hold");
  a_hold_float: assert property (!BUS_GRANT_ACK_N_O |-> !STROBE_OE_O && !DATA_OE_O
    && !ADDR_HI_OE_O && !ADDR_LO_OE_O) else $error("pins driven during hold");
  a_grant_keep: assert property (!BUS_GRANT_ACK_N_O && !HOLD_REQ_N_I |=> !BUS_GRANT_ACK_N_O)
    else $error("grant dropped early");
  a_grant_end: assert property (!BUS_GRANT_ACK_N_O && HOLD_REQ_N_I |-> ##[1:2] BUS_GRANT_ACK_N_O)
    else $error("grant not withdrawn");

  // ----
  // cycles
  // ----
  a_ale_addr: assert property (REQ_VALID_I && REQ_READY_O |=> ADDR_LATCH_O
    && ADDR_O == $past(REQ_ADDR_I)) else $error("address not latched");
  a_rd_strobe: assert property (REQ_VALID_I && REQ_READY_O && !REQ_WRITE_I |-> ##2
    !READ_STROBE_N_O && LOW_BYTE_STORE_N_O) else $error("read strobe missing");
  a_store_data: assert property (!LOW_BYTE_STORE_N_O |-> DATA_OE_O && READ_STROBE_N_O)
    else $error("store strobe without data");
  a_wait_hold: assert property (!WAIT_N_I && !(READ_STROBE_N_O && LOW_BYTE_STORE_N_O) |=>
    $stable(READ_STROBE_N_O) && $stable(LOW_BYTE_STORE_N_O) && !RSP_VALID_O)
    else $error("wait not honoured");
  a_strobe_end: assert property (!READ_STROBE_N_O && WAIT_N_I |=> READ_STROBE_N_O && RSP_VALID_O)
    else $error("read strobe overran");
  a_mux_addr: assert property (ADDR_LATCH_O && !ADDR_LO_OE_O |-> DATA_OE_O
    && DATA_O[7:0] == ADDR_O[7:0]) else $error("mux address wrong");

  c_hold: cover property (!BUS_GRANT_ACK_N_O);
  c_wait: cover property (!WAIT_N_I && !READ_STROBE_N_O);
  c_mux: cover property (ADDR_LATCH_O && !ADDR_LO_OE_O);
endmodule

bind ebs_bus_ctrl ebs_bus_asserts u_chk
(
  .CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I), .REQ_VALID_I(REQ_VALID_I),
  .REQ_READY_O(REQ_READY_O), .REQ_WRITE_I(REQ_WRITE_I), .REQ_ADDR_I(REQ_ADDR_I),
  .RSP_VALID_O(RSP_VALID_O), .ADDR_O(ADDR_O), .ADDR_HI_OE_O(ADDR_HI_OE_O),
  .ADDR_LO_OE_O(ADDR_LO_OE_O), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
  .LOW_BYTE_STORE_N_O(LOW_BYTE_STORE_N_O), .READ_STROBE_N_O(READ_STROBE_N_O),
  .STROBE_OE_O(STROBE_OE_O), .ADDR_LATCH_O(ADDR_LATCH_O), .HOLD_REQ_N_I(HOLD_REQ_N_I),
  .BUS_GRANT_ACK_N_O(BUS_GRANT_ACK_N_O), .WAIT_N_I(WAIT_N_I)
);

// ===== testbench/tb_ebs_bus_ctrl.sv
`timescale 1ns/1ps

module tb_ebs_bus_ctrl;
  localparam logic [15:0] PAT = 16'hC3A5;
  logic        clk, rst_b, cfg_single, cfg_bus16, cfg_mux8, hold_n, ack_n, wait_n;
  logic        req_valid, req_ready, req_write, req_wide, rsp_valid, ale;
  logic        addr_hi_oe, addr_lo_oe, data_oe, lo_n, hi_n, rd_n, stb_oe;
  logic [19:0] req_addr, addr, al, lo_c, hi_c, rd_c, ale_c, lat;
  logic [15:0] req_wdata, rsp_rdata, data_in, data_out, wd;
  logic [7:0]  mx;
  int          err_total, n_tests, cyc;

  ebs_bus_ctrl DUT
  (
    .CLK_SYS_I(clk), .RST_B_I(rst_b), .CFG_SINGLE_STORE_I(cfg_single),
    .CFG_BUS16_I(cfg_bus16), .CFG_MUX8_I(cfg_mux8), .REQ_VALID_I(req_valid),
    .REQ_READY_O(req_ready), .REQ_WRITE_I(req_write), .REQ_WIDE_I(req_wide),
    .REQ_ADDR_I(req_addr), .REQ_WDATA_I(req_wdata), .RSP_VALID_O(rsp_valid),
    .RSP_RDATA_O(rsp_rdata), .ADDR_O(addr), .ADDR_HI_OE_O(addr_hi_oe),
    .ADDR_LO_OE_O(addr_lo_oe), .DATA_I(data_in), .DATA_O(data_out), .DATA_OE_O(data_oe),
    .LOW_BYTE_STORE_N_O(lo_n), .HIGH_BYTE_STORE_N_O(hi_n), .READ_STROBE_N_O(rd_n),
    .STROBE_OE_O(stb_oe), .ADDR_LATCH_O(ale), .HOLD_REQ_N_I(hold_n),
    .BUS_GRANT_ACK_N_O(ack_n), .WAIT_N_I(wait_n)
  );

  ebs_ext_mem #(.PAT(PAT)) u_mem
  (
    .clk_i(clk), .addr_i(addr), .ale_i(ale), .rd_n_i(rd_n), .data_o(data_in)
  );

  // ----
  // bus monitor
  // ----
  always @(negedge clk)
  begin
    if (!lo_n) lo_c++;
    if (!hi_n) hi_c++;
    if (!rd_n) rd_c++;
    if (data_oe && (!lo_n || !hi_n)) wd = data_out;
    if (ale)
    begin
      ale_c++;
      al = addr;
      mx = data_out[7:0];
    end
  end

  // ----
  // helpers
  // ----
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // nw: strobe cycles stretched by holding the wait input low
  task automatic xfer(input logic w, input logic wide, input logic [19:0] a,
                      input logic [15:0] d, input int nw);
    int k;
    k = 0;
    lo_c = 0;
    hi_c = 0;
    rd_c = 0;
    ale_c = 0;
    req_write = w;
    req_wide = wide;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 40)
    begin
      wait_n = !(rd_n === 1'b0 || lo_n === 1'b0) || nw == 0;
      if (wait_n === 1'b0) nw--;
      @(negedge clk);
      lat++;
    end
    wait_n = 1'b1;
    // let the byte enable drop before the next call clears the counters
    @(negedge clk);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_split;
    cfg_single = 1'b0;
    cfg_bus16 = 1'b1;
    xfer(1'b1, 1'b0, 20'h12344, 16'h00A5, 0);
    chk(lo_c, 20'h1);
    chk(hi_c, 20'h0);
    chk(20'(wd[7:0]), 20'hA5);
    chk(al, 20'h12344);
    xfer(1'b1, 1'b0, 20'h12345, 16'h005A, 0);
    chk(hi_c, 20'h1);
    chk(lo_c, 20'h0);
    chk(20'(wd[15:8]), 20'h5A);
  endtask

  task automatic t_read;
    xfer(1'b0, 1'b1, 20'h00100, 16'h0000, 0);
    chk(rd_c, 20'h1);
    chk(20'(rsp_rdata), 20'(PAT ^ 16'h0100));
    xfer(1'b0, 1'b0, 20'h00301, 16'h0000, 2);
    chk(rd_c, 20'h3);
    chk(lat, 20'h5);
    chk(20'(rsp_rdata), 20'((PAT ^ 16'h0301) >> 8));
  endtask

  task automatic t_single;
    cfg_single = 1'b1;
    cfg_bus16 = 1'b0;
    xfer(1'b1, 1'b0, 20'h00021, 16'h0033, 0);
    chk(lo_c, 20'h1);
    chk(20'(hi_c != 0), 20'h1);
    chk(20'(wd[7:0]), 20'h33);
    xfer(1'b1, 1'b0, 20'h00020, 16'h0044, 0);
    chk(hi_c, 20'h0);
  endtask

  task automatic t_mux8;
    cfg_mux8 = 1'b1;
    xfer(1'b1, 1'b0, 20'h5A0C2, 16'h0077, 0);
    chk(20'(mx), 20'hC2);
    chk(20'(wd[7:0]), 20'h77);
    chk(al, 20'h5A0C2);
    cfg_mux8 = 1'b0;
  endtask

  task automatic t_hold;
    cfg_single = 1'b0;
    cfg_bus16 = 1'b1;
    hold_n = 1'b0;
    repeat (3) @(negedge clk);
    chk(20'(ack_n), 20'h0);
    chk(20'({stb_oe, data_oe, addr_hi_oe, addr_lo_oe}), 20'h0);
    fork
      begin
        repeat (5) @(negedge clk);
        chk(ale_c, 20'h0);
        chk(20'(ack_n), 20'h0);
        hold_n = 1'b1;
      end
      xfer(1'b0, 1'b1, 20'h00200, 16'h0000, 0);
    join
    chk(20'(ack_n), 20'h1);
    chk(rd_c, 20'h1);
  endtask

  // reset in mid-run, during a hold, then a stretched read
  task automatic t_reset;
    hold_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b0;
    @(negedge clk);
    chk(20'({ack_n, ale, data_oe, req_ready}), 20'h8);
    hold_n = 1'b1;
    rst_b = 1'b1;
    xfer(1'b0, 1'b0, 20'h00402, 16'h0000, 1);
    chk(rd_c, 20'h2);
    chk(20'(rsp_rdata), 20'((PAT ^ 16'h0402) & 16'h00FF));
  endtask

  // ----
  // main
  // ----
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      tally_and_finish;
    end
  end

  initial
  begin
    {rst_b, cfg_single, cfg_mux8, req_valid, req_write, req_wide} = '0;
    {cfg_bus16, hold_n, wait_n} = 3'h7;
    req_addr = 20'h00000;
    req_wdata = 16'h0000;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    t_split;
    t_read;
    t_single;
    t_mux8;
    t_hold;
    t_reset;
    tally_and_finish;
  end
endmodule
